// ==== rbs_host.sv ====
// Serial host model that shifts frames into the block and captures the answer on the data output.
`timescale 1ns/1ns
module rbs_host (
  // Clock
  input  wire logic        clk,
  // Serial pins
  output logic             sclk,
  output logic             frame_sel_n,
  output logic             sdi,
  input  wire logic        sdo,
  input  wire logic        sdo_oe,
  // Captured answer
  output logic             done,
  output logic [23:0]      rx_word,
  output logic             rx_oe
);
  initial
  begin
    sclk        = 1'b0;
    frame_sel_n = 1'b1;
    sdi         = 1'b0;
    done        = 1'b0;
    rx_word     = 24'h000000;
    rx_oe       = 1'b0;
  end

  // ****************************************************************
  // One frame, MSB first, clock idles low and stands still outside frames
  // ****************************************************************
  task automatic frame(input logic [23:0] tx, input int half);
    int i;
    @(posedge clk);
    frame_sel_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (i = 23; i >= 0; i--)
    begin
      // A released data output shows the inverse of its last value.
      rx_word[i] <= sdo_oe ? sdo : ~sdo;
      if (i == 23) rx_oe <= sdo_oe;
      sclk <= 1'b1;
      sdi  <= tx[i];
      repeat (half) @(posedge clk);
      sclk <= 1'b0;
      repeat (half) @(posedge clk);
    end
    // A released data line shows the inverse of its last value.
    frame_sel_n <= 1'b1;
    sdi         <= ~sdi;
    done        <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ==== rbs_pin_sync.sv ====
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ns
module rbs_pin_sync #(
  parameter int                W         = 1,
  parameter logic [W-1:0]      RST_VAL   = '0
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            resetn,
  input  wire logic            ce,
  // Pins and filtered levels
  input  wire logic [W-1:0]    pin,
  output logic      [W-1:0]    level
);

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic s1;
      logic s2;
      logic s3;

      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          s1       <= RST_VAL[i];
          s2       <= RST_VAL[i];
          s3       <= RST_VAL[i];
          level[i] <= RST_VAL[i];
        end
        else if (ce)
        begin
          s1 <= pin[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3)
          begin
            level[i] <= s3;
          end
        end
      end
    end
  endgenerate

endmodule

// ==== rbs_pkg.sv ====
// Constants shared by the readback select block: frame layout, addresses, modes, reset values.
package rbs_pkg;

  // ****************************************************************
  // Serial frame layout
  // ****************************************************************
  localparam int          FRAME_BITS = 24;
  localparam int          CNT_W      = 5;
  localparam logic [4:0]  FRAME_LEN  = 5'h18;
  localparam int          DEV_LSB    = 22;
  localparam int          ADDR_LSB   = 16;
  localparam int          DATA_W     = 16;
  localparam int          WORD_W     = 22;
  localparam int          DEV_W      = 2;

  // ****************************************************************
  // Register addresses
  // ****************************************************************
  localparam logic [4:0]  ADDR_NOP    = 5'h00;
  localparam logic [4:0]  ADDR_SELF   = 5'h13;
  localparam logic [4:0]  ADDR_STATUS = 5'h16;
  localparam logic [4:0]  ADDR_LAST   = 5'h18;
  localparam logic [4:0]  ADDR_DEVID  = 5'h1c;

  // ****************************************************************
  // Readback select register fields
  // ****************************************************************
  localparam int          FAULT_BIT  = 21;
  localparam int          MODE_LSB   = 5;
  localparam int          TARGET_LSB = 0;
  localparam logic [WORD_W-1:0] SELF_RESET = 22'h130000;
  localparam logic [1:0]  MODE_RESET   = 2'h0;
  localparam logic [4:0]  TARGET_RESET = 5'h00;

  // ****************************************************************
  // Readback modes
  // ****************************************************************
  localparam logic [1:0]  MODE_TWO_STAGE = 2'h0;
  localparam logic [1:0]  MODE_AUTO      = 2'h1;
  localparam logic [1:0]  MODE_SHARED    = 2'h2;
  localparam logic [1:0]  MODE_ALT       = 2'h3;

  // ****************************************************************
  // Pin input synchroniser
  // ****************************************************************
  localparam int          PIN_W     = 6;
  localparam logic [5:0]  PIN_RESET = 6'h10;

endpackage

// ==== rbs_readback_ctl.sv ====
// Serial target with readback select register and four readback modes.
`timescale 1ns/1ns

// What this block does
// - Five-bit writable target field holds the address returned by two-stage readback.
// - Bit 21 of the select register reads the inverse of the alert pin level.
// - Two-bit mode field at bits 6:5 resets to zero, two-stage readback.
// - Mode 01 shifts the status word out on the data output every frame.
// - Mode 10 sets an internal flag after each valid write addressed here.
// - Mode 10 drives status at frame start only when that flag is set.
// - Mode 10 lets devices share frame select, told apart by strapped address pins.
// - Mode 11 alternates status and the previous frame's instruction frame by frame.
// - Target codes 0x00 to 0x18 select the register at that same address.
module rbs_readback_ctl (
  // Clock, reset and enable
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  // Serial pins
  input  wire logic        sclk,
  input  wire logic        frame_sel_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  // Straps and alert pin level
  input  wire logic [1:0]  hw_addr,
  input  wire logic        fault_pin,
  // Write port to the other registers
  output logic             wr_strobe,
  output logic [4:0]       wr_addr,
  output logic [15:0]      wr_data,
  // Read port to the other registers
  output logic [4:0]       rd_addr,
  input  wire logic [15:0] rd_data,
  input  wire logic [15:0] status_data,
  // Select register contents
  output logic [1:0]       readback_mode,
  output logic [4:0]       readback_target
);

  // ****************************************************************
  // Pin synchronisation and edge detection
  // ****************************************************************
  logic [rbs_pkg::PIN_W-1:0]      pin_lvl;
  logic                           sclk_q;
  logic                           fsel_q;
  logic                           sclk_rise;
  logic                           sclk_fall;
  logic                           frame_start;
  logic                           frame_end;
  logic                           fault_lvl;
  logic [1:0]                     strap;

  rbs_pin_sync #(
    .W       (rbs_pkg::PIN_W),
    .RST_VAL (rbs_pkg::PIN_RESET)
  ) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .pin    ({sclk, frame_sel_n, sdi, fault_pin, hw_addr}),
    .level  (pin_lvl)
  );

  assign fault_lvl   = pin_lvl[2];
  assign strap       = pin_lvl[1:0];
  assign sclk_rise   = pin_lvl[5] & ~sclk_q;
  assign sclk_fall   = ~pin_lvl[5] & sclk_q;
  assign frame_start = ~pin_lvl[4] & fsel_q;
  assign frame_end   = pin_lvl[4] & ~fsel_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_q <= 1'b0;
      fsel_q <= 1'b1;
    end
    else if (ce)
    begin
      sclk_q <= pin_lvl[5];
      fsel_q <= pin_lvl[4];
    end
  end

  // ****************************************************************
  // Frame capture
  // ****************************************************************
  logic [rbs_pkg::FRAME_BITS-1:0] shift_in;
  logic [rbs_pkg::CNT_W-1:0]      bit_cnt;
  logic                           valid_wr;
  logic                           wr_self;
  logic [4:0]                     in_addr;

  assign in_addr  = shift_in[rbs_pkg::ADDR_LSB +: 5];
  assign valid_wr = frame_end && (bit_cnt == rbs_pkg::FRAME_LEN)
                    && (shift_in[rbs_pkg::DEV_LSB +: rbs_pkg::DEV_W] == strap);
  assign wr_self  = valid_wr && (in_addr == rbs_pkg::ADDR_SELF);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      shift_in <= '0;
      bit_cnt  <= '0;
    end
    else if (ce)
    begin
      if (frame_start)
      begin
        shift_in <= '0;
        bit_cnt  <= '0;
      end
      else if (!fsel_q && sclk_fall)
      begin
        shift_in <= {shift_in[rbs_pkg::FRAME_BITS-2:0], pin_lvl[3]};
        if (bit_cnt != '1)
        begin
          bit_cnt <= bit_cnt + 5'h01;
        end
      end
    end
  end

  // ****************************************************************
  // Readback select register
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      readback_mode   <= rbs_pkg::MODE_RESET;
      readback_target <= rbs_pkg::TARGET_RESET;
      rd_addr         <= rbs_pkg::TARGET_RESET;
    end
    else if (ce && wr_self)
    begin
      readback_mode   <= shift_in[rbs_pkg::MODE_LSB +: 2];
      readback_target <= shift_in[rbs_pkg::TARGET_LSB +: 5];
      rd_addr         <= shift_in[rbs_pkg::TARGET_LSB +: 5];
    end
  end

  // ****************************************************************
  // Write port to the other registers
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_strobe <= 1'b0;
      wr_addr   <= '0;
      wr_data   <= '0;
    end
    else if (ce)
    begin
      wr_strobe <= valid_wr && !wr_self;
      if (valid_wr && !wr_self)
      begin
        wr_addr <= in_addr;
        wr_data <= shift_in[rbs_pkg::DATA_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Readback words
  // ****************************************************************
  logic [15:0]                    rd_q;
  logic [15:0]                    status_q;
  logic [rbs_pkg::WORD_W-1:0]     self_word;
  logic [rbs_pkg::WORD_W-1:0]     tgt_word;
  logic [rbs_pkg::WORD_W-1:0]     stat_word;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_q     <= '0;
      status_q <= '0;
    end
    else if (ce)
    begin
      rd_q     <= rd_data;
      status_q <= status_data;
    end
  end

  // Reserved bits 15:7 read as zero.
  assign self_word = {~fault_lvl, rbs_pkg::ADDR_SELF, 9'h000,
                      readback_mode, readback_target};
  assign tgt_word  = (readback_target == rbs_pkg::ADDR_SELF) ? self_word
                     : {~fault_lvl, readback_target, rd_q};
  assign stat_word = {~fault_lvl, rbs_pkg::ADDR_STATUS, status_q};

  // ****************************************************************
  // Mode flags
  // ****************************************************************
  logic                           wr_flag;
  logic                           alt_echo;
  logic [rbs_pkg::FRAME_BITS-1:0] prev_instr;

  // In mode 10 a valid write wins over the consume at frame start.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_flag <= 1'b0;
    end
    else if (ce)
    begin
      if (valid_wr && readback_mode == rbs_pkg::MODE_SHARED)
      begin
        wr_flag <= 1'b1;
      end
      else if (frame_start)
      begin
        wr_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      alt_echo   <= 1'b0;
      prev_instr <= '0;
    end
    else if (ce)
    begin
      if (frame_start && readback_mode == rbs_pkg::MODE_ALT)
      begin
        alt_echo <= ~alt_echo;
      end
      if (frame_end)
      begin
        prev_instr <= shift_in;
      end
    end
  end

  // ****************************************************************
  // Serial output
  // ****************************************************************
  logic [rbs_pkg::FRAME_BITS-1:0] out_sr;
  logic [rbs_pkg::FRAME_BITS-1:0] next_out;
  logic                           next_oe;

  always_comb
  begin
    next_out = {2'b00, tgt_word};
    next_oe  = 1'b1;
    unique case (readback_mode)
      rbs_pkg::MODE_TWO_STAGE: next_out = {2'b00, tgt_word};
      rbs_pkg::MODE_AUTO:      next_out = {2'b00, stat_word};
      rbs_pkg::MODE_SHARED:
      begin
        next_out = {2'b00, stat_word};
        next_oe  = wr_flag;
      end
      rbs_pkg::MODE_ALT:
        next_out = alt_echo ? prev_instr : {2'b00, stat_word};
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_sr <= '0;
      sdo    <= 1'b0;
      sdo_oe <= 1'b0;
    end
    else if (ce)
    begin
      if (frame_start)
      begin
        out_sr <= next_out;
        sdo    <= next_out[rbs_pkg::FRAME_BITS-1];
        sdo_oe <= next_oe;
      end
      else if (frame_end)
      begin
        sdo_oe <= 1'b0;
      end
      else if (!fsel_q && sclk_rise)
      begin
        out_sr <= {out_sr[rbs_pkg::FRAME_BITS-2:0], 1'b0};
        sdo    <= out_sr[rbs_pkg::FRAME_BITS-2];
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_start_in(logic [1:0] m);
    ce && frame_start && readback_mode == m;
  endsequence

  a_target_write: assert property (@(posedge clk) disable iff (!resetn)
    ce && wr_self |=> readback_target == $past(shift_in[4:0]) && rd_addr == readback_target)
    else $error("target field not loaded by a valid write");

  a_fault_bit: assert property (@(posedge clk) disable iff (!resetn)
    ce && frame_start && readback_mode == rbs_pkg::MODE_AUTO
    |=> out_sr[rbs_pkg::FAULT_BIT] == ~$past(fault_lvl))
    else $error("fault bit not the inverse of the pin");

  a_mode_reset: assert property (@(posedge clk)
    $rose(resetn) |-> readback_mode == rbs_pkg::MODE_TWO_STAGE && readback_target == 5'h00)
    else $error("mode field not zero after reset");

  a_auto_status: assert property (@(posedge clk) disable iff (!resetn)
    s_start_in(rbs_pkg::MODE_AUTO) |=> sdo_oe && out_sr[15:0] == $past(status_q)
    && out_sr[20:16] == rbs_pkg::ADDR_STATUS)
    else $error("status word not loaded in autostatus mode");

  a_flag_set: assert property (@(posedge clk) disable iff (!resetn)
    ce && valid_wr && readback_mode == rbs_pkg::MODE_SHARED |=> wr_flag)
    else $error("write flag not set after valid write");

  a_shared_gate: assert property (@(posedge clk) disable iff (!resetn)
    s_start_in(rbs_pkg::MODE_SHARED) |=> sdo_oe == $past(wr_flag) && !wr_flag)
    else $error("shared mode output not gated by write flag");

  a_oe_release: assert property (@(posedge clk) disable iff (!resetn)
    ce && frame_end |=> !sdo_oe)
    else $error("data output still driven after frame end");

  a_alt_echo: assert property (@(posedge clk) disable iff (!resetn)
    s_start_in(rbs_pkg::MODE_ALT) |=> out_sr == ($past(alt_echo) ? $past(prev_instr)
    : {2'b00, $past(stat_word)}) && alt_echo != $past(alt_echo))
    else $error("alternate mode picked the wrong word");

  a_two_stage: assert property (@(posedge clk) disable iff (!resetn)
    s_start_in(rbs_pkg::MODE_TWO_STAGE) |=> sdo_oe && out_sr[20:16] == readback_target)
    else $error("two-stage readback returned the wrong address");

endmodule

// ==== rbs_readback_ctl_tb.sv ====
// Self-checking testbench for the readback select block.
`timescale 1ns/1ns
module rbs_readback_ctl_tb;
  logic clk, resetn, ce, sclk, frame_sel_n, sdi, sdo, sdo_oe, fault_pin, wr_strobe;
  logic [1:0]  hw_addr, readback_mode, m_mode;
  logic [4:0]  wr_addr, rd_addr, readback_target, m_target;
  logic [15:0] wr_data, rd_data, status_data;
  logic        host_done, host_oe, flag, alt;
  logic [23:0] host_word, last_tx;
  logic [25:0] exp_q[$];
  logic [25:0] note_w;
  logic [20:0] wr_q[$];
  logic [20:0] wr_w;
  logic [31:0] seed;
  int          n_errors, check_count;
  // Entries: {valid device, mode, address, target}; codes 0x19 to 0x1b never sent.
  localparam logic [12:0] PLAN [23] = '{
    {1'b1, 2'h0, 5'h13, 5'h13}, {1'b1, 2'h0, 5'h13, 5'h01}, {1'b1, 2'h0, 5'h13, 5'h16},
    {1'b1, 2'h0, 5'h13, 5'h18}, {1'b1, 2'h0, 5'h13, 5'h1c}, {1'b0, 2'h0, 5'h05, 5'h00},
    {1'b1, 2'h0, 5'h05, 5'h00}, {1'b1, 2'h1, 5'h13, 5'h13}, {1'b1, 2'h0, 5'h07, 5'h00},
    {1'b0, 2'h0, 5'h08, 5'h00}, {1'b1, 2'h2, 5'h13, 5'h13}, {1'b0, 2'h0, 5'h05, 5'h00},
    {1'b0, 2'h0, 5'h05, 5'h00}, {1'b1, 2'h0, 5'h05, 5'h00}, {1'b1, 2'h0, 5'h06, 5'h00},
    {1'b0, 2'h0, 5'h07, 5'h00}, {1'b0, 2'h0, 5'h07, 5'h00}, {1'b1, 2'h3, 5'h13, 5'h13},
    {1'b0, 2'h0, 5'h09, 5'h00}, {1'b1, 2'h0, 5'h0a, 5'h00}, {1'b1, 2'h0, 5'h0b, 5'h00},
    {1'b1, 2'h0, 5'h13, 5'h16}, {1'b1, 2'h0, 5'h00, 5'h00}};

  assign rd_data = (rd_addr == rbs_pkg::ADDR_STATUS) ? status_data : {rd_addr, 11'h2a5};

  rbs_readback_ctl dut (.clk(clk), .resetn(resetn), .ce(ce), .sclk(sclk),
    .frame_sel_n(frame_sel_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .hw_addr(hw_addr),
    .fault_pin(fault_pin), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_addr(rd_addr), .rd_data(rd_data), .status_data(status_data),
    .readback_mode(readback_mode), .readback_target(readback_target));

  rbs_host host (.clk(clk), .sclk(sclk), .frame_sel_n(frame_sel_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .done(host_done), .rx_word(host_word), .rx_oe(host_oe));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [23:0] seen, input logic [23:0] expect_v);
    check_count++;
    if (seen !== expect_v)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expect_v);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Notes the expected answer and write, then runs one frame through the host.
  task automatic send(input logic [12:0] e);
    logic [31:0] rnd;
    logic [15:0] dat;
    logic [23:0] tx, stat_w;
    rnd = next_rand();
    dat = (e[9:5] == rbs_pkg::ADDR_SELF) ? {9'h000, e[11:10], e[4:0]} : rnd[15:0];
    @(posedge clk);
    fault_pin   <= rnd[21];
    status_data <= rnd[31:16];
    // Drops the clock enable for three idle cycles when rnd[22] is set, so that frozen state is exercised.
    ce          <= ~rnd[22];
    repeat (3) @(posedge clk);
    ce          <= 1'b1;
    repeat (5) @(posedge clk);
    tx     = {e[12] ? hw_addr : ~hw_addr, rnd[20], e[9:5], dat};
    stat_w = {2'b00, ~fault_pin, rbs_pkg::ADDR_STATUS, status_data};
    case (m_mode)
      rbs_pkg::MODE_TWO_STAGE: exp_q.push_back({2'b11, 2'b00, ~fault_pin, m_target,
        (m_target == rbs_pkg::ADDR_SELF) ? {9'h000, m_mode, m_target} :
        (m_target == rbs_pkg::ADDR_STATUS) ? status_data : {m_target, 11'h2a5}});
      rbs_pkg::MODE_AUTO:      exp_q.push_back({2'b11, stat_w});
      rbs_pkg::MODE_SHARED:    exp_q.push_back({1'b1, flag, stat_w});
      default:                 exp_q.push_back({2'b11, alt ? last_tx : stat_w});
    endcase
    if (e[12] && e[9:5] != rbs_pkg::ADDR_SELF) wr_q.push_back({e[9:5], dat});
    flag    = (m_mode == rbs_pkg::MODE_SHARED) && e[12];
    alt     = (m_mode == rbs_pkg::MODE_ALT) && !alt;
    last_tx = tx;
    if (e[12] && e[9:5] == rbs_pkg::ADDR_SELF)
    begin
      m_mode   = e[11:10];
      m_target = e[4:0];
    end
    host.frame(tx, 5);
  endtask

  // ****************************************************************
  // Result watcher
  // ****************************************************************
  always @(posedge clk)
  begin
    if (host_done === 1'b1)
    begin
      note_w = exp_q.pop_front();
      if (note_w[25]) check({23'h0, host_oe}, {23'h0, note_w[24]});
      if (note_w[25] && note_w[24]) check(host_word, note_w[23:0]);
    end
    if (wr_strobe === 1'b1)
    begin
      wr_w = wr_q.pop_front();
      check({3'h0, wr_addr, wr_data}, {3'h0, wr_w});
    end
  end

  // ****************************************************************
  // Clock, reset and main sequence
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end

  initial
  begin
    resetn      = 1'b0;
    hw_addr     = 2'h2;
    fault_pin   = 1'b0;
    status_data = 16'h0000;
    seed        = 32'd71;
    m_mode      = rbs_pkg::MODE_RESET;
    m_target    = rbs_pkg::TARGET_RESET;
    flag        = 1'b0;
    alt         = 1'b0;
    ce          = 1'b1;
    last_tx     = 24'h000000;
    n_errors    = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
    foreach (PLAN[k]) send(PLAN[k]);
    repeat (10) @(posedge clk);
    check({22'h0, readback_mode}, {22'h0, m_mode});
    check({19'h0, readback_target}, {19'h0, m_target});
    check(24'(exp_q.size() + wr_q.size()), 24'h000000);
    wrap_up();
  end
endmodule
